// file: pkg/assm_pkg.sv
// package: per-axis safety state machine constants, types and register map
package assm_pkg;

   // ****************************************************************
   // axis states
   // ****************************************************************
   typedef enum logic [4:0] {
      ST_STOP  = 5'b00001,
      ST_FAULT = 5'b00010,
      ST_RUN   = 5'b00100,
      ST_SAFE  = 5'b01000,
      ST_SS1   = 5'b10000
   } assm_state_type;

   localparam int NUM_AXES_DEF = 2;
   localparam int NUM_FUNCS    = 8;

   // safety function bit positions inside a function-active vector
   localparam int FN_SSO = 0;
   localparam int FN_SBC = 1;
   localparam int FN_SRL = 2;
   localparam int FN_SS1 = 3;

   // default mask of functions that never count as motion monitoring
   localparam logic [7:0] NON_MOTION_MASK = 8'h07;

   // ****************************************************************
   // register map (byte offsets)
   // ****************************************************************
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h04;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
   localparam logic [7:0] ADDR_STATE    = 8'h0c;

   // control bits
   localparam int CTRL_TO_EN    = 0;
   localparam int CTRL_BRAKE_MON = 1;

   localparam logic [31:0] CTRL_RESET = 32'h00000001;

   // interrupt status bits, one group of three per axis
   localparam int IRQ_PER_AXIS = 3;
   localparam int IRQ_ENTER_STOP  = 0;
   localparam int IRQ_ENTER_FAULT = 1;
   localparam int IRQ_ENTER_SS1   = 2;

   localparam int STATE_BITS = 5;

   // per-axis request bundle
   typedef struct packed {
      logic       stop_req;
      logic       torque_off_req;
      logic       config_req;
      logic       axis_error;
      logic       ack;
      logic       ss1_done;
      logic [7:0] func_active;
   } assm_axis_in_type;

endpackage : assm_pkg

// file: src/assm_top.sv
// per-axis safety state machines with apb register slave
// ****************************************************************
// What this block does
// RULE1 - torque off removes motor torque, any substate
// RULE2 - torque off to run only on restart
// RULE3 - stop or torque-off request enters stop substate
// RULE4 - new configuration runs safe-stop-one, ends stop
// RULE5 - global or axis error: safe-stop-one then fault
// RULE6 - fault substate reached only through safe-stop-one; an error in the stop substate enters fault directly
// RULE7 - self-test error counts as fault cause
// RULE8 - error during stop substate moves to fault
// RULE9 - fault leaves to stop only after acknowledgement
// RULE10 - normal run only while no monitoring active
// RULE11 - monitoring active moves run to safe run
// RULE12 - monitoring inactive moves safe run to run
// RULE13 - stop or fault in run enters safe-stop-one
// RULE14 - safe-stop-one acts on own axis only
// RULE15 - sso, brake, restart lock never monitoring functions
// RULE16 - restart needs rising edge of stop request
// RULE17 - after reset torque off, then automatic startup
// RULE18 - safe-stop-one ends in stop or fault by cause
// RULE19 - one machine per axis, reset to stop
// ****************************************************************
`timescale 1ns/1ps

module assm_top #(
   parameter int NUM_AXES = assm_pkg::NUM_AXES_DEF
) (
   input  wire logic                          core_clk,
   input  wire logic                          rst_n,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [7:0]                    paddr,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire assm_pkg::assm_axis_in_type [NUM_AXES-1:0] axis_in,
   input  wire logic                          global_error,
   input  wire logic                          selftest_error,
   input  wire logic                          startup_done,
   output logic      [NUM_AXES-1:0]           torque_off,
   output logic      [NUM_AXES-1:0]           ss1_active,
   output assm_pkg::assm_state_type [NUM_AXES-1:0] axis_state,
   output logic                               irq
);

   localparam int IRQ_W = NUM_AXES * assm_pkg::IRQ_PER_AXIS;

   // ****************************************************************
   // input synchronisers
   // ****************************************************************
   // requests come from pins, so each passes two flip-flops
   localparam int IN_W = $bits(assm_pkg::assm_axis_in_type);
   logic [NUM_AXES*IN_W-1:0] in_meta_reg;
   logic [NUM_AXES*IN_W-1:0] in_sync_reg;
   logic [2:0]               glb_meta_reg;
   logic [2:0]               glb_sync_reg;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         in_meta_reg  <= '0;
         in_sync_reg  <= '0;
         glb_meta_reg <= '0;
         glb_sync_reg <= '0;
      end else begin
         in_meta_reg  <= axis_in;
         in_sync_reg  <= in_meta_reg;
         glb_meta_reg <= {startup_done, selftest_error, global_error};
         glb_sync_reg <= glb_meta_reg;
      end
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   logic [31:0]    ctrl_reg;
   logic [IRQ_W-1:0] irq_stat_reg;
   logic [IRQ_W-1:0] irq_mask_reg;
   logic [IRQ_W-1:0] irq_event;
   logic           wr_en;
   logic           rd_en;
   logic           addr_ok;

   // ****************************************************************
   // apb decode
   // ****************************************************************
   assign addr_ok = (paddr == assm_pkg::ADDR_CTRL) || (paddr == assm_pkg::ADDR_IRQ_STAT) ||
                    (paddr == assm_pkg::ADDR_IRQ_MASK) || (paddr == assm_pkg::ADDR_STATE);
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_ok;
   assign wr_en   = psel && penable && pwrite && addr_ok;
   assign rd_en   = psel && !penable && !pwrite;

   // ****************************************************************
   // control register
   // ****************************************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= assm_pkg::CTRL_RESET;
      end else if (wr_en && paddr == assm_pkg::ADDR_CTRL) begin
         ctrl_reg <= pwdata;
      end
   end

   // ****************************************************************
   // interrupt mask
   // ****************************************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask_reg <= '0;
      end else if (wr_en && paddr == assm_pkg::ADDR_IRQ_MASK) begin
         irq_mask_reg <= pwdata[IRQ_W-1:0];
      end
   end

   // ****************************************************************
   // interrupt status
   // ****************************************************************
   // set wins over the write-one clear
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_reg <= '0;
      end else if (wr_en && paddr == assm_pkg::ADDR_IRQ_STAT) begin
         irq_stat_reg <= (irq_stat_reg & ~pwdata[IRQ_W-1:0]) | irq_event;
      end else begin
         irq_stat_reg <= irq_stat_reg | irq_event;
      end
   end

   // ****************************************************************
   // interrupt line
   // ****************************************************************
   assign irq = |(irq_stat_reg & irq_mask_reg);

   // ****************************************************************
   // state word
   // ****************************************************************
   logic [31:0] state_word;
   always_comb begin
      state_word = '0;
      for (int a = 0; a < NUM_AXES; a++) begin
         if (a * assm_pkg::STATE_BITS + assm_pkg::STATE_BITS <= 32)
            state_word[a*assm_pkg::STATE_BITS +: assm_pkg::STATE_BITS] = axis_state[a];
      end
   end

   // ****************************************************************
   // read data
   // ****************************************************************
   logic [31:0] rd_data_next;
   always_comb begin
      rd_data_next = '0;
      unique case (paddr)
         assm_pkg::ADDR_CTRL:     rd_data_next = ctrl_reg;
         assm_pkg::ADDR_IRQ_STAT: rd_data_next = 32'(irq_stat_reg);
         assm_pkg::ADDR_IRQ_MASK: rd_data_next = 32'(irq_mask_reg);
         assm_pkg::ADDR_STATE:    rd_data_next = state_word;
         default:                 rd_data_next = '0;
      endcase
   end

   // read data captured in setup, held through the access phase
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata <= '0;
      end else if (rd_en) begin
         prdata <= rd_data_next;
      end
   end

   // ****************************************************************
   // per-axis state machines
   // ****************************************************************
   // ****************************************************************
   // shared fault causes
   // ****************************************************************
   logic any_error;
   logic ready_up;
   assign any_error = glb_sync_reg[0] || glb_sync_reg[1]; // RULE5 RULE7
   assign ready_up  = glb_sync_reg[2];

   genvar g;
   generate
      for (g = 0; g < NUM_AXES; g++) begin : gen_axis // RULE19
         assm_pkg::assm_axis_in_type in_s;
         assm_pkg::assm_state_type   state_reg;
         assm_pkg::assm_state_type   state_next;
         logic                       stop_prev_reg;
         logic                       cause_fault_reg;
         logic                       booted_reg;
         logic                       stop_hit;
         logic                       err_hit;
         logic                       restart;
         logic                       to_hit;
         logic                       auto_start;
         logic                       motion;
         logic [7:0]                 excl;

         // ****************************************************************
         // axis fields
         // ****************************************************************
         assign in_s = in_sync_reg[g*IN_W +: IN_W];

         // ****************************************************************
         // motion and request decode
         // ****************************************************************
         // ss1 only excluded when brake ramp monitoring is off
         always_comb begin
            excl = assm_pkg::NON_MOTION_MASK; // RULE15
            excl[assm_pkg::FN_SS1] = !ctrl_reg[assm_pkg::CTRL_BRAKE_MON]; // RULE15
         end
         assign motion   = |(in_s.func_active & ~excl); // RULE10
         assign stop_hit = in_s.stop_req ||
                           (ctrl_reg[assm_pkg::CTRL_TO_EN] && in_s.torque_off_req); // RULE3
         assign err_hit  = any_error || in_s.axis_error; // RULE5
         // ****************************************************************
         // restart detect
         // ****************************************************************
         // the restart edge is the stop input itself, so only the
         // torque-off and configuration requests may block it
         assign to_hit     = ctrl_reg[assm_pkg::CTRL_TO_EN] && in_s.torque_off_req; // RULE3
         // first restart after power-up needs no user action
         assign auto_start = !booted_reg && ready_up && !in_s.stop_req; // RULE17
         assign restart    = ((in_s.stop_req && !stop_prev_reg) || auto_start) &&
                             !to_hit && !in_s.config_req; // RULE16 RULE17

         // ****************************************************************
         // restart edge memory
         // ****************************************************************
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               stop_prev_reg <= 1'b1;
            end else begin
               stop_prev_reg <= in_s.stop_req;
            end
         end

         // ****************************************************************
         // power-up start
         // ****************************************************************
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               booted_reg <= 1'b0;
            end else if (ready_up) begin
               booted_reg <= 1'b1;
            end
         end

         // ****************************************************************
         // next state
         // ****************************************************************
         always_comb begin
            state_next = state_reg;
            unique case (state_reg)
               assm_pkg::ST_STOP: begin
                  if (err_hit) begin
                     state_next = assm_pkg::ST_FAULT; // RULE8
                  end else if (restart) begin
                     state_next = assm_pkg::ST_RUN; // RULE2
                  end
               end
               assm_pkg::ST_FAULT: begin
                  if (in_s.ack && !err_hit) begin
                     state_next = assm_pkg::ST_STOP; // RULE9
                  end
               end
               assm_pkg::ST_RUN: begin
                  if (err_hit || stop_hit || in_s.config_req) begin
                     state_next = assm_pkg::ST_SS1; // RULE13 RULE4
                  end else if (motion) begin
                     state_next = assm_pkg::ST_SAFE; // RULE11
                  end
               end
               assm_pkg::ST_SAFE: begin
                  if (err_hit || stop_hit || in_s.config_req) begin
                     state_next = assm_pkg::ST_SS1; // RULE13 RULE4
                  end else if (!motion) begin
                     state_next = assm_pkg::ST_RUN; // RULE12
                  end
               end
               assm_pkg::ST_SS1: begin
                  if (in_s.ss1_done) begin
                     state_next = (cause_fault_reg || err_hit) ? assm_pkg::ST_FAULT
                                                               : assm_pkg::ST_STOP; // RULE18 RULE6
                  end
               end
               default: state_next = assm_pkg::ST_STOP;
            endcase
         end

         // ****************************************************************
         // state register
         // ****************************************************************
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               state_reg <= assm_pkg::ST_STOP; // RULE19 RULE17
            end else begin
               state_reg <= state_next;
            end
         end

         // ****************************************************************
         // stop cause
         // ****************************************************************
         // cause remembered so the sequence ends in the matching substate
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               cause_fault_reg <= 1'b0;
            end else if (state_reg != assm_pkg::ST_SS1 && state_next == assm_pkg::ST_SS1) begin
               cause_fault_reg <= err_hit; // RULE5
            end else if (state_reg == assm_pkg::ST_SS1 && err_hit) begin
               cause_fault_reg <= 1'b1; // RULE5
            end
         end

         // ****************************************************************
         // power stage outputs
         // ****************************************************************
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               torque_off[g] <= 1'b1;
               ss1_active[g] <= 1'b0;
            end else begin
               torque_off[g] <= (state_next == assm_pkg::ST_STOP) ||
                                (state_next == assm_pkg::ST_FAULT); // RULE1
               ss1_active[g] <= (state_next == assm_pkg::ST_SS1); // RULE14
            end
         end

         // ****************************************************************
         // interrupt events
         // ****************************************************************
         assign axis_state[g] = state_reg;
         assign irq_event[g*assm_pkg::IRQ_PER_AXIS + assm_pkg::IRQ_ENTER_STOP] =
            (state_reg != assm_pkg::ST_STOP) && (state_next == assm_pkg::ST_STOP);
         assign irq_event[g*assm_pkg::IRQ_PER_AXIS + assm_pkg::IRQ_ENTER_FAULT] =
            (state_reg != assm_pkg::ST_FAULT) && (state_next == assm_pkg::ST_FAULT);
         assign irq_event[g*assm_pkg::IRQ_PER_AXIS + assm_pkg::IRQ_ENTER_SS1] =
            (state_reg != assm_pkg::ST_SS1) && (state_next == assm_pkg::ST_SS1);
      end
   endgenerate

endmodule : assm_top

// file: test/assm_checker.sv
// checker: port assertions for the axis safety state machine
`timescale 1ns/1ps
module assm_checker #(
   parameter int NUM_AXES = 2
) (
   input wire logic                                      core_clk,
   input wire logic                                      rst_n,
   input wire assm_pkg::assm_axis_in_type [NUM_AXES-1:0] axis_in,
   input wire logic                                      global_error,
   input wire logic [NUM_AXES-1:0]                       torque_off,
   input wire logic [NUM_AXES-1:0]                       ss1_active,
   input wire assm_pkg::assm_state_type [NUM_AXES-1:0]   axis_state
);
   // ****************************************************************
   // axis 0 watched here, axis 1 only by the bench
   // ****************************************************************
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   wire assm_pkg::assm_state_type st = axis_state[0];
   wire ack0 = axis_in[0].ack;
   wire stop0 = axis_in[0].stop_req;
   // bit 3 counts only with brake monitoring, so this is a necessary cause only
   wire mot0 = |axis_in[0].func_active[7:3];
   // inputs pass a two-flop sync, so a cause shows 2 to 4 edges back
   sequence ss1_leave;
      st == assm_pkg::ST_SS1 ##1 st != assm_pkg::ST_SS1;
   endsequence
   torque_free_a: assert property (
      torque_off[0] == (st inside {assm_pkg::ST_STOP, assm_pkg::ST_FAULT})) else $error("torque off wrong");
   ss1_flag_a: assert property (ss1_active[0] == (st == assm_pkg::ST_SS1))
      else $error("ss1 flag wrong");
   fault_entry_a: assert property (st == assm_pkg::ST_FAULT && $past(st) != assm_pkg::ST_FAULT
      |-> $past(st) inside {assm_pkg::ST_SS1, assm_pkg::ST_STOP}) else $error("bad fault entry");
   run_entry_a: assert property (st == assm_pkg::ST_RUN && $past(st) != assm_pkg::ST_RUN
      |-> $past(st) inside {assm_pkg::ST_STOP, assm_pkg::ST_SAFE}) else $error("bad run entry");
   ack_gate_a: assert property (st == assm_pkg::ST_STOP && $past(st) == assm_pkg::ST_FAULT
      |-> $past(ack0, 2) || $past(ack0, 3) || $past(ack0, 4)) else $error("fault left without ack");
   ss1_end_a: assert property (ss1_leave |-> st inside {assm_pkg::ST_STOP, assm_pkg::ST_FAULT})
      else $error("bad ss1 exit");
   motion_a: assert property (st == assm_pkg::ST_SAFE && $past(st) == assm_pkg::ST_RUN
      |-> $past(mot0, 2) || $past(mot0, 3) || $past(mot0, 4)) else $error("safe run without motion");
   stop_react_a: assert property ($rose(stop0) && st inside {assm_pkg::ST_RUN, assm_pkg::ST_SAFE}
      |-> ##[1:6] st == assm_pkg::ST_SS1) else $error("stop ignored");
   err_react_a: assert property ($rose(global_error) && st == assm_pkg::ST_RUN
      |-> ##[1:6] st == assm_pkg::ST_SS1) else $error("error ignored");
endmodule : assm_checker

bind assm_top assm_checker #(.NUM_AXES(NUM_AXES)) i_assm_checker (.core_clk(core_clk), .rst_n(rst_n),
   .axis_in(axis_in), .global_error(global_error), .torque_off(torque_off), .ss1_active(ss1_active),
   .axis_state(axis_state));

// file: test/assm_partner.sv
// partner: drive power stage that finishes safe-stop-one per axis
`timescale 1ns/1ps
module assm_partner #(
   parameter int NUM_AXES = 2
) (
   input wire logic                core_clk,
   input wire logic                rst_n,
   input wire logic                slow,
   input wire logic [NUM_AXES-1:0] ss1_active,
   output logic     [NUM_AXES-1:0] ss1_done
);
   int cnt [NUM_AXES];
   // one ramp timer per axis: a stop on one axis never ends another
   always @(posedge core_clk or negedge rst_n) begin
      for (int a = 0; a < NUM_AXES; a++) begin
         if (!rst_n || !ss1_active[a]) begin
            cnt[a] <= 0;
            ss1_done[a] <= 1'b0;
         end else begin
            cnt[a] <= cnt[a] + 1;
            ss1_done[a] <= (cnt[a] >= (slow ? 20 : 2));
         end
      end
   end
endmodule : assm_partner

// file: test/test_assm_top.sv
// testbench: axis state machines, apb registers, interrupt and power stage
`timescale 1ns/1ps
module test_assm_top;
   // ****************************************************************
   // stimulus and checking
   // ****************************************************************
   logic                             core_clk, pready, pslverr, irq;
   logic                             rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
   logic                             global_error = 1'b0, selftest_error = 1'b0, startup_done = 1'b0;
   logic [7:0]                       paddr = 8'h00;
   logic [31:0]                      pwdata = 32'h0, prdata, seed = 32'h9bef;
   logic [1:0]                       torque_off, ss1_active, ss1_done;
   assm_pkg::assm_axis_in_type [1:0] ain = '0, axis_in;
   assm_pkg::assm_state_type [1:0]   axis_state, prev;
   logic [32:0]                      rq[$];
   logic [5:0]                       sq[$];
   int                               fails = 0, check_count = 0;

   assm_top #(.NUM_AXES(2)) i_assm_top (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .axis_in(axis_in), .global_error(global_error), .selftest_error(selftest_error),
      .startup_done(startup_done), .torque_off(torque_off), .ss1_active(ss1_active),
      .axis_state(axis_state), .irq(irq));
   assm_partner #(.NUM_AXES(2)) i_assm_partner (.core_clk(core_clk), .rst_n(rst_n), .slow(slow),
      .ss1_active(ss1_active), .ss1_done(ss1_done));

   always_comb begin
      axis_in = ain;
      axis_in[0].ss1_done = ss1_done[0];
      axis_in[1].ss1_done = ss1_done[1];
   end

   task automatic test_done();
      if (fails == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done

   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic ex(input logic a, input assm_pkg::assm_state_type s);
      sq.push_back({a, s});
   endtask : ex

   // an empty queue still waits: any state change then is flagged
   task automatic settle();
      for (int i = 0; i < 80 && sq.size() > 0; i++)
         @(posedge core_clk);
      repeat (8) @(posedge core_clk);
      chk(33'(sq.size()), 33'h0);
   endtask : settle

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w)
         rq.push_back(e);
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1)
         @(posedge core_clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // result watcher: reads and state changes, oldest note first
   always @(posedge core_clk) begin
      if (psel && penable && pready && !pwrite)
         chk({pslverr, prdata}, rq.size() ? rq.pop_front() : 33'h1ffffffff);
      for (int a = 0; a < 2; a++)
         if (rst_n && axis_state[a] !== prev[a])
            chk(33'({a[0], axis_state[a]}), 33'(sq.size() ? sq.pop_front() : 6'h3f));
      prev <= axis_state;
   end

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   initial begin
      #200000;
      fails++;
      test_done();
   end

   initial begin
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      apb(1'b0, assm_pkg::ADDR_STATE, 32'h0, 33'h21);
      apb(1'b0, assm_pkg::ADDR_CTRL, 32'h0, 33'h1);
      apb(1'b0, 8'h10, 32'h0, 33'h100000000);
      chk(33'(torque_off), 33'h3);
      ex(0, assm_pkg::ST_RUN);
      ex(1, assm_pkg::ST_RUN);
      startup_done <= 1'b1;
      settle();
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         ex(0, assm_pkg::ST_SAFE);
         ain[0].func_active <= {seed[3:0] | 4'h1, 1'b0, seed[6:4]};
         settle();
         ex(0, assm_pkg::ST_RUN);
         ain[0].func_active <= {5'h00, seed[6:4]};
         settle();
      end
      ain[0].func_active <= 8'h0f;
      settle();
      ex(0, assm_pkg::ST_SAFE);
      apb(1'b1, assm_pkg::ADDR_CTRL, 32'h3, 33'h0);
      settle();
      ex(0, assm_pkg::ST_RUN);
      apb(1'b1, assm_pkg::ADDR_CTRL, 32'h1, 33'h0);
      ain[0].func_active <= 8'h00;
      settle();
      apb(1'b1, assm_pkg::ADDR_IRQ_MASK, 32'h1, 33'h0);
      // stop, torque off, new configuration, axis error in turn
      for (int k = 0; k < 4; k++) begin
         ex(0, assm_pkg::ST_SS1);
         ex(0, k == 3 ? assm_pkg::ST_FAULT : assm_pkg::ST_STOP);
         ain[0][13-k] <= 1'b1;
         settle();
         if (k == 0) begin
            chk(33'(irq), 33'h1);
            apb(1'b0, assm_pkg::ADDR_IRQ_STAT, 32'h0, 33'h5);
            apb(1'b1, assm_pkg::ADDR_IRQ_STAT, 32'h5, 33'h0);
            apb(1'b0, assm_pkg::ADDR_IRQ_STAT, 32'h0, 33'h0);
            chk(33'(irq), 33'h0);
         end
         ain[0][13-k] <= 1'b0;
         settle();
         if (k == 3) begin
            ex(0, assm_pkg::ST_STOP);
            ain[0].ack <= 1'b1;
            settle();
            ain[0].ack <= 1'b0;
         end
         ex(0, assm_pkg::ST_RUN);
         @(posedge core_clk);
         ain[0].stop_req <= 1'b1;
         @(posedge core_clk);
         ain[0].stop_req <= 1'b0;
         settle();
      end
      // global error from run, then self-test error from stop
      for (int e = 0; e < 2; e++) begin
         slow <= 1'b1;
         for (int a = 0; a < 2 && e == 0; a++)
            ex(a[0], assm_pkg::ST_SS1);
         ex(0, assm_pkg::ST_FAULT);
         ex(1, assm_pkg::ST_FAULT);
         global_error <= (e == 0);
         selftest_error <= (e == 1);
         settle();
         global_error <= 1'b0;
         selftest_error <= 1'b0;
         settle();
         ex(0, assm_pkg::ST_STOP);
         ex(1, assm_pkg::ST_STOP);
         ain[0].ack <= 1'b1;
         ain[1].ack <= 1'b1;
         settle();
         ain[0].ack <= 1'b0;
         ain[1].ack <= 1'b0;
      end
      test_done();
   end
endmodule : test_assm_top
